// file: verilog/ciap_regs.svh
// Constants of the card arming and polling link and its host registers.
`ifndef CIAP_REGS_SVH
`define CIAP_REGS_SVH

// ----------------------------------------------------------------------
// Control word bit positions and codes
// ----------------------------------------------------------------------
`define CIAP_TME_BIT 4
`define CIAP_SYE_BIT 5
`define CIAP_ISL_BIT 7
`define CIAP_IEN_BIT 8
`define CIAP_CTL_INPUT 12'h0a0
`define CIAP_CTL_INTR 12'h130
`define CIAP_CTL_OUTPUT 12'h020

// ----------------------------------------------------------------------
// Answers on the link
// ----------------------------------------------------------------------
`define CIAP_IRQ_MARK 16'h2710
`define CIAP_STB_SRQ 8'h40

// ----------------------------------------------------------------------
// Timer card tick
// ----------------------------------------------------------------------
`define CIAP_CLK_NS 20
`define CIAP_TMR_TICK_NS 1000
`define CIAP_TMR_TICK_CYC (`CIAP_TMR_TICK_NS / `CIAP_CLK_NS)

// ----------------------------------------------------------------------
// Host register offsets and fields
// ----------------------------------------------------------------------
`define CIAP_OFS_CMD 8'h00
`define CIAP_OFS_RSP 8'h04
`define CIAP_OFS_STAT 8'h08
`define CIAP_OFS_ISR 8'h0c
`define CIAP_OFS_IMR 8'h10
`define CIAP_CMD_SLOT_LSB 12
`define CIAP_CMD_GATE_BIT 14
`define CIAP_CMD_KIND_LSB 16
`define CIAP_ISR_SRQ 0
`define CIAP_ISR_DONE 1
`define CIAP_ISR_REFUSED 2

`endif

// file: verilog/ciap_pkg.sv
// Types shared by both ends of the card arming and polling link.
package ciap_pkg;

  localparam int CIAP_NSLOT = 4;
  localparam int CIAP_SLOT_W = 2;
  localparam int CIAP_WORD_W = 12;

  typedef enum logic [1:0] {
    K_CTL = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h2,
    K_POLL = 2'h3
  } ciap_kind_e;

  typedef enum logic [1:0] {
    C_DIN = 2'h0,
    C_PINT = 2'h1,
    C_TMR = 2'h2,
    C_EVS = 2'h3
  } ciap_card_e;

  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_NE = 2'h1,
    CMP_GT = 2'h2,
    CMP_LT = 2'h3
  } ciap_cmp_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_WAIT = 2'h3
  } ciap_host_st_e;

  // Fixed population of the cage: one card of each kind.
  function automatic ciap_card_e ciap_slot_type(input int s);
    case (s)
      0: ciap_slot_type = C_DIN;
      1: ciap_slot_type = C_PINT;
      2: ciap_slot_type = C_TMR;
      default: ciap_slot_type = C_EVS;
    endcase
  endfunction

endpackage

// file: verilog/ciap_link_if.sv
// Word link between the host end and the card cage end.
`timescale 1ns/1ps
interface ciap_link_if;
  import ciap_pkg::*;
  logic cmd_vld;
  ciap_kind_e cmd_kind;
  logic [CIAP_SLOT_W-1:0] cmd_slot;
  logic cmd_gate;
  logic [CIAP_WORD_W-1:0] cmd_data;
  logic rsp_vld;
  logic [15:0] rsp_data;
  logic srq;

  modport dev (
    input cmd_vld, cmd_kind, cmd_slot, cmd_gate, cmd_data,
    output rsp_vld, rsp_data, srq
  );
  modport host (
    output cmd_vld, cmd_kind, cmd_slot, cmd_gate, cmd_data,
    input rsp_vld, rsp_data, srq
  );
endinterface

// file: verilog/ciap_dev.sv
// Card cage end: mode bits, interrupt-capable cards, request and polls.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "ciap_regs.svh"

// How it works
// - Code 00240 sets input select, system enable.
// - Gated address in input mode arms card.
// - Code 00460 sets interrupt, system, timing bits.
// - Request stays low until armed card interrupts.
// - Serial poll byte is 64 after request.
// - Ungated address reads card without new gate.
// - Read data carries 10000 when card interrupted.
// - Code 00040 output mode; gated data disarms.
// - Strap arms cards when interrupt mode set.
// - Process card: ones init, word recycles, zeros disarm.
// - Host recycles process card before disarming it.
// - Process card trips on any twelve edges.
// - Timer loads duration, interrupts at end, zero disarms.
// - Timer recycles on gated duration in output mode.
// - Event card compares external word to reference.
// - Unreset interrupted card requests again later.
module ciap_dev
  import ciap_pkg::*;
#(
  parameter int NSLOT = CIAP_NSLOT,
  parameter int TICK_CYC = `CIAP_TMR_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to the host end
  ciap_link_if.dev link,
  // Field pins of the cards
  input wire logic [NSLOT-1:0][CIAP_WORD_W-1:0] ext_word_i,
  input wire logic [NSLOT-1:0] ext_flag_i,
  input wire logic [1:0] cmp_sel_i,
  input wire logic group_arm_strap_i,
  // Card state for the user
  output logic [NSLOT-1:0] armed_o,
  output logic [NSLOT-1:0] done_o
);

  localparam int W = CIAP_WORD_W;

  if (NSLOT != CIAP_NSLOT || TICK_CYC < 1 ||
      TICK_CYC > 65536) begin : g_chk_param
    $error("ciap_dev: NSLOT or TICK_CYC out of range");
  end

  // --------------------------------------------------------------------
  // Mode bits
  // --------------------------------------------------------------------
  logic [W-1:0] mode_q;
  logic is_ctl, input_select_bit, timing_mode_bit, interrupt_enable_bit, int_mode;

  assign is_ctl = link.cmd_vld & (link.cmd_kind == K_CTL);
  assign input_select_bit = mode_q[`CIAP_ISL_BIT];
  assign timing_mode_bit = mode_q[`CIAP_TME_BIT];
  assign interrupt_enable_bit = mode_q[`CIAP_IEN_BIT];
  assign int_mode = timing_mode_bit & interrupt_enable_bit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= '0;
    end else if (is_ctl) begin
      mode_q <= link.cmd_data;
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [NSLOT-1:0][W-1:0] word_m_q, word_s_q, word_p_q;
  logic [NSLOT-1:0] flag_m_q, flag_s_q, flag_p_q;
  logic [1:0] sel_m_q, sel_s_q;
  logic strap_m_q, strap_s_q;

  // No reset: the chains follow the pins through reset, so the edge
  // detectors leave reset at the pins' own level and see no false edge.
  always_ff @(posedge clk_i) begin
    word_m_q <= ext_word_i;
    word_s_q <= word_m_q;
    word_p_q <= word_s_q;
    flag_m_q <= ext_flag_i;
    flag_s_q <= flag_m_q;
    flag_p_q <= flag_s_q;
    sel_m_q <= cmp_sel_i;
    sel_s_q <= sel_m_q;
    strap_m_q <= group_arm_strap_i;
    strap_s_q <= strap_m_q;
  end

  // --------------------------------------------------------------------
  // Timer tick prescaler
  // --------------------------------------------------------------------
  logic [16:0] pre_q;
  logic tick;

  assign tick = (pre_q == 17'(TICK_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 17'h1;
    end
  end

  // --------------------------------------------------------------------
  // Card slots
  // --------------------------------------------------------------------
  logic [NSLOT-1:0] armed_q, done_q;
  logic [NSLOT-1:0][W-1:0] val_q;
  logic grp_arm;

  // Group arming happens on the control word that opens interrupt mode.
  assign grp_arm = strap_s_q & is_ctl & link.cmd_data[`CIAP_IEN_BIT] &
                   link.cmd_data[`CIAP_TME_BIT];

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    localparam ciap_card_e TYPE = ciap_slot_type(s);
    logic sel, ind_arm, out_wr, hit, cmp;
    logic [W-1:0] cap, ref_q, cnt_q;

    assign sel = link.cmd_vld & link.cmd_gate &
                 (link.cmd_slot == CIAP_SLOT_W'(s));
    assign ind_arm = sel & (link.cmd_kind == K_ADDR) & input_select_bit & ~timing_mode_bit;
    assign out_wr = sel & (link.cmd_kind == K_DATA) & ~input_select_bit & ~timing_mode_bit;

    always_comb begin
      cmp = 1'b0;
      case (sel_s_q)
        CMP_EQ: cmp = (word_s_q[s] == ref_q);
        CMP_NE: cmp = (word_s_q[s] != ref_q);
        CMP_GT: cmp = (word_s_q[s] > ref_q);
        default: cmp = (word_s_q[s] < ref_q);
      endcase
      hit = 1'b0;
      cap = val_q[s];
      case (TYPE)
        C_DIN: begin
          hit = flag_p_q[s] & ~flag_s_q[s];
          cap = word_s_q[s];
        end
        C_PINT: begin
          hit = |(word_s_q[s] ^ word_p_q[s]);
          cap = word_s_q[s] ^ word_p_q[s];
        end
        C_TMR: hit = tick & (cnt_q == W'(1));
        default: begin
          // Outside interrupt mode the event card keeps nothing.
          hit = int_mode & cmp;
          cap = word_s_q[s];
        end
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        armed_q[s] <= 1'b0;
        done_q[s] <= 1'b0;
        val_q[s] <= '0;
        ref_q <= '0;
        cnt_q <= '0;
      end else begin
        if (ind_arm || grp_arm) begin
          armed_q[s] <= 1'b1;
          done_q[s] <= 1'b0;
        end
        if (TYPE == C_TMR && armed_q[s] && tick && cnt_q != '0) begin
          cnt_q <= cnt_q - W'(1);
        end
        if (out_wr) begin
          case (TYPE)
            C_PINT: begin
              if (&link.cmd_data) begin
                armed_q[s] <= 1'b1;
                done_q[s] <= 1'b0;
                val_q[s] <= '0;
              end else if (link.cmd_data == '0) begin
                armed_q[s] <= 1'b0;
                done_q[s] <= 1'b0;
              end else if (link.cmd_data == val_q[s]) begin
                done_q[s] <= 1'b0;
                val_q[s] <= '0;
              end
            end
            C_TMR: begin
              val_q[s] <= link.cmd_data;
              cnt_q <= link.cmd_data;
              done_q[s] <= 1'b0;
              if (link.cmd_data == '0) begin
                armed_q[s] <= 1'b0;
              end
            end
            C_EVS: begin
              ref_q <= link.cmd_data;
              armed_q[s] <= 1'b0;
              done_q[s] <= 1'b0;
            end
            default: begin
              armed_q[s] <= 1'b0;
              done_q[s] <= 1'b0;
            end
          endcase
        end
        // A trip in the same cycle as a recycle is kept only if done_q was clear; a card already done loses it.
        if (hit && armed_q[s] && !done_q[s]) begin
          done_q[s] <= 1'b1;
          val_q[s] <= cap;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Service request
  // --------------------------------------------------------------------
  logic cond, cond_q, srq_q, is_poll;

  assign is_poll = link.cmd_vld & (link.cmd_kind == K_POLL);
  // Only a rise of the condition requests service, so a poll can clear
  // the line while flags remain set; reopening interrupt mode raises it.
  assign cond = int_mode & |(armed_q & done_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_q <= 1'b0;
      srq_q <= 1'b0;
    end else begin
      cond_q <= cond;
      if (cond && !cond_q) begin
        srq_q <= 1'b1;
      end else if (is_poll) begin
        srq_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Answers to polls and reads
  // --------------------------------------------------------------------
  logic rsp_vld_q, is_read;
  logic [15:0] rsp_data_q;

  assign is_read = link.cmd_vld & (link.cmd_kind == K_ADDR) & ~link.cmd_gate;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_vld_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_vld_q <= is_poll | is_read;
      if (is_poll) begin
        rsp_data_q <= srq_q ? {8'h00, `CIAP_STB_SRQ} : 16'h0000;
      end else if (is_read) begin
        rsp_data_q <= {4'h0, val_q[link.cmd_slot]} +
                      (done_q[link.cmd_slot] ? `CIAP_IRQ_MARK : 16'h0000);
      end
    end
  end

  assign link.rsp_vld = rsp_vld_q;
  assign link.rsp_data = rsp_data_q;
  assign link.srq = srq_q;
  assign armed_o = armed_q;
  assign done_o = done_q;

endmodule // ciap_dev

// file: verilog/ciap_host.sv
// Host end: Wishbone registers that issue words and collect answers.
`timescale 1ns/1ps
`include "ciap_regs.svh"

module ciap_host
  import ciap_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Link to the card cage
  ciap_link_if.host link
);

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr;
  logic [31:0] wm;
  logic cmd_wr;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cmd_wr = wr & (wb_adr_i == `CIAP_OFS_CMD) & (wb_sel_i == 4'hf);

  // --------------------------------------------------------------------
  // Word sequencer
  // --------------------------------------------------------------------
  ciap_host_st_e st_q;
  logic cmd_vld_q;
  ciap_kind_e kind_q;
  logic [CIAP_SLOT_W-1:0] slot_q;
  logic gate_q;
  logic [CIAP_WORD_W-1:0] data_q;
  logic [15:0] rsp_q;
  logic [CIAP_NSLOT-1:0] recyc_q;
  logic done_ev;
  logic refuse;
  ciap_kind_e wkind;
  logic [CIAP_SLOT_W-1:0] wslot;
  logic [CIAP_WORD_W-1:0] wdata;

  assign wkind = ciap_kind_e'(wb_dat_i[`CIAP_CMD_KIND_LSB +: 2]);
  assign wslot = wb_dat_i[`CIAP_CMD_SLOT_LSB +: CIAP_SLOT_W];
  assign wdata = wb_dat_i[CIAP_WORD_W-1:0];
  // A process card may not be cleared to zeros before it was recycled.
  assign refuse = cmd_wr & (st_q == ST_IDLE) & (wkind == K_DATA) &
                  (ciap_slot_type(int'(wslot)) == C_PINT) &
                  (wdata == '0) & ~recyc_q[wslot];
  assign done_ev = ((st_q == ST_SEND) &
                    !(kind_q == K_POLL || (kind_q == K_ADDR && !gate_q))) |
                   ((st_q == ST_WAIT) & link.rsp_vld);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cmd_vld_q <= 1'b0;
      kind_q <= K_CTL;
      slot_q <= '0;
      gate_q <= 1'b0;
      data_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (cmd_wr && !refuse) begin
            kind_q <= wkind;
            slot_q <= wslot;
            gate_q <= wb_dat_i[`CIAP_CMD_GATE_BIT];
            data_q <= wdata;
            cmd_vld_q <= 1'b1;
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          cmd_vld_q <= 1'b0;
          st_q <= done_ev ? ST_IDLE : ST_WAIT;
        end
        ST_WAIT: begin
          if (link.rsp_vld) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          cmd_vld_q <= 1'b0;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_q <= '0;
    end else if (st_q == ST_WAIT && link.rsp_vld) begin
      rsp_q <= link.rsp_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recyc_q <= '0;
    end else if (cmd_vld_q && kind_q == K_DATA && gate_q) begin
      if (data_q == '0) begin
        recyc_q[slot_q] <= 1'b0;
      end else if (!(&data_q)) begin
        recyc_q[slot_q] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------
  logic [2:0] isr_q;
  logic [2:0] imr_q;
  logic [2:0] isr_set;
  logic [2:0] isr_clr;
  logic srq_p_q;
  logic irq_q;

  assign isr_set = {refuse, done_ev, link.srq & ~srq_p_q};
  assign isr_clr = (wr && wb_adr_i == `CIAP_OFS_ISR) ?
                   wb_dat_i[2:0] & wm[2:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_q <= '0;
      imr_q <= '0;
      srq_p_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      srq_p_q <= link.srq;
      isr_q <= (isr_q & ~isr_clr) | isr_set;
      if (wr && wb_adr_i == `CIAP_OFS_IMR) begin
        imr_q <= (imr_q & ~wm[2:0]) | (wb_dat_i[2:0] & wm[2:0]);
      end
      irq_q <= |(isr_q & imr_q);
    end
  end

  // --------------------------------------------------------------------
  // Read path and acknowledge
  // --------------------------------------------------------------------
  logic [31:0] dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        case (wb_adr_i)
          `CIAP_OFS_CMD: dat_q <= {14'h0, kind_q, 1'b0, gate_q, slot_q,
                                   data_q};
          `CIAP_OFS_RSP: dat_q <= {16'h0, rsp_q};
          `CIAP_OFS_STAT: dat_q <= {30'h0, st_q != ST_IDLE, link.srq};
          `CIAP_OFS_ISR: dat_q <= {29'h0, isr_q};
          `CIAP_OFS_IMR: dat_q <= {29'h0, imr_q};
          default: dat_q <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o = irq_q;
  assign link.cmd_vld = cmd_vld_q;
  assign link.cmd_kind = kind_q;
  assign link.cmd_slot = slot_q;
  assign link.cmd_gate = gate_q;
  assign link.cmd_data = data_q;

endmodule // ciap_host

// file: testbench/ciap_link_props.sv
// Concurrent checks on the word link between the host end and the cage end.
`timescale 1ns/1ps
`include "ciap_regs.svh"
module ciap_link_props
  import ciap_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic cmd_vld,
  input wire ciap_kind_e cmd_kind,
  input wire logic [CIAP_SLOT_W-1:0] cmd_slot,
  input wire logic cmd_gate,
  input wire logic [CIAP_WORD_W-1:0] cmd_data,
  input wire logic rsp_vld,
  input wire logic [15:0] rsp_data,
  input wire logic srq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic intr_q;

  // Every control word reloads the mode bits, so the mirror follows them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intr_q <= 1'b0;
    end else if (cmd_vld && cmd_kind == K_CTL) begin
      intr_q <= cmd_data[`CIAP_TME_BIT] && cmd_data[`CIAP_IEN_BIT];
    end
  end

  sequence s_poll;
    cmd_vld && cmd_kind == K_POLL;
  endsequence
  sequence s_read;
    cmd_vld && cmd_kind == K_ADDR && !cmd_gate;
  endsequence

  a_poll_answered: assert property (s_poll |=> rsp_vld)
    else $error("poll not answered");
  a_poll_byte_set: assert property (
    s_poll ##0 srq |=> rsp_data == {8'h00, `CIAP_STB_SRQ})
    else $error("poll byte wrong while requesting");
  a_poll_byte_clear: assert property (
    s_poll ##0 !srq |=> rsp_data == 16'h0000)
    else $error("poll byte wrong while quiet");
  a_read_answered: assert property (s_read |=> rsp_vld)
    else $error("ungated read not answered");
  a_read_mark_range: assert property (s_read |=>
    rsp_data < 16'h1000 || (rsp_data >= `CIAP_IRQ_MARK &&
    rsp_data - `CIAP_IRQ_MARK < 16'h1000))
    else $error("read data outside marked ranges");
  a_rsp_has_cause: assert property (rsp_vld |-> $past(cmd_vld) &&
    ($past(cmd_kind) == K_POLL ||
    ($past(cmd_kind) == K_ADDR && !$past(cmd_gate))))
    else $error("answer without read or poll");
  a_rsp_single: assert property (rsp_vld |=> !rsp_vld)
    else $error("answer longer than one cycle");
  a_srq_needs_mode: assert property (
    $rose(srq) |-> $past(intr_q) || $past(intr_q, 2))
    else $error("request raised outside interrupt mode");
  a_srq_until_poll: assert property (
    srq && !(cmd_vld && cmd_kind == K_POLL) |=> srq)
    else $error("request dropped without poll");
  a_word_spacing: assert property (cmd_vld |=> !cmd_vld)
    else $error("words sent back to back");
endmodule // ciap_link_props

// file: testbench/card_interrupt_arming_poll_tb.sv
// Self-checking bench of both link ends, driven over Wishbone.
`timescale 1ns/1ps
`include "ciap_regs.svh"
module card_interrupt_arming_poll_tb;
  import ciap_pkg::*;
  localparam logic [11:0] CI = `CIAP_CTL_INPUT;
  localparam logic [11:0] CX = `CIAP_CTL_INTR;
  localparam logic [11:0] CO = `CIAP_CTL_OUTPUT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic irq;
  logic [CIAP_NSLOT-1:0][CIAP_WORD_W-1:0] ext_word = '0;
  logic [3:0] ext_flag = 4'hf;
  logic [1:0] cmp_sel = 2'h0;
  logic strap = 1'b0;
  logic [3:0] armed;
  logic [3:0] done;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  ciap_link_if link ();
  ciap_dev #(.TICK_CYC(2)) ciap_dev_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .ext_word_i(ext_word), .ext_flag_i(ext_flag),
    .cmp_sel_i(cmp_sel), .group_arm_strap_i(strap), .armed_o(armed),
    .done_o(done));
  ciap_host ciap_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .link(link));
  ciap_link_props ciap_link_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_vld(link.cmd_vld), .cmd_kind(link.cmd_kind),
    .cmd_slot(link.cmd_slot), .cmd_gate(link.cmd_gate),
    .cmd_data(link.cmd_data), .rsp_vld(link.rsp_vld),
    .rsp_data(link.rsp_data), .srq(link.srq));

  always #10 clk_i = ~clk_i;

  // The whole run needs a few hundred cycles, so this only cuts a hang.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // A command write is ignored while busy, so each word waits it out.
  task automatic send(input ciap_kind_e k, input logic [1:0] s,
                      input logic g, input logic [11:0] w);
    wb(1'b1, `CIAP_OFS_CMD, {14'h0, k, 1'b0, g, s, w});
    wb(1'b0, `CIAP_OFS_STAT, 32'h0);
    while (rd[1] === 1'b1) wb(1'b0, `CIAP_OFS_STAT, 32'h0);
  endtask

  task automatic wsrq;
    int n;
    n = 0;
    while (link.srq !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_i);
    end
    chk(link.srq, 1);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    rdc(`CIAP_OFS_IMR, 0);
    wb(1'b1, 8'h14, 32'hffff_ffff);
    rdc(8'h14, 0);
    rdc(`CIAP_OFS_STAT, 0);
  endtask

  task automatic t_digital;
    ext_word[0] <= 12'h123;
    send(K_CTL, 0, 1, CI);
    send(K_ADDR, 0, 1, 0);
    chk(armed, 4'h1);
    send(K_CTL, 0, 1, CX);
    repeat (6) @(posedge clk_i);
    chk(link.srq, 0);
    ext_flag[0] <= 1'b0;
    wsrq();
    chk(irq, 0);
    wb(1'b1, `CIAP_OFS_IMR, 32'h1);
    rdc(`CIAP_OFS_IMR, 1);
    chk(irq, 1);
    send(K_POLL, 0, 0, 0);
    rdc(`CIAP_OFS_RSP, 64);
    send(K_POLL, 0, 0, 0);
    rdc(`CIAP_OFS_RSP, 0);
    send(K_CTL, 0, 1, CI);
    send(K_ADDR, 0, 0, 0);
    rdc(`CIAP_OFS_RSP, `CIAP_IRQ_MARK + 16'h0123);
    chk(done, 4'h1);
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 0, 1, 0);
    chk(armed, 4'h0);
    wb(1'b1, `CIAP_OFS_ISR, 32'h7);
    rdc(`CIAP_OFS_ISR, 0);
    chk(irq, 0);
  endtask

  task automatic t_process;
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 1, 1, 12'hfff);
    chk(armed[1], 1);
    send(K_CTL, 0, 1, CX);
    ext_word[1] <= 12'h020;
    wsrq();
    chk(done[1], 1);
    send(K_POLL, 0, 0, 0);
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 1, 1, 0);
    wb(1'b0, `CIAP_OFS_ISR, 32'h0);
    chk(rd[2], 1);
    chk(armed[1], 1);
    send(K_CTL, 0, 1, CX);
    wsrq();
    send(K_POLL, 0, 0, 0);
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 1, 1, 12'h020);
    chk(done[1], 0);
    send(K_DATA, 1, 1, 0);
    chk(armed[1], 0);
  endtask

  task automatic t_timer;
    send(K_CTL, 0, 1, CI);
    send(K_ADDR, 2, 1, 0);
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 2, 1, 12'h010);
    chk(done[2], 0);
    send(K_CTL, 0, 1, CX);
    wsrq();
    chk(done[2], 1);
    send(K_POLL, 0, 0, 0);
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 2, 1, 12'h005);
    chk({armed[2], done[2]}, 2'b10);
    send(K_DATA, 2, 1, 0);
    chk(armed[2], 0);
  endtask

  // Words that make each compare mode false, then true, against 0x100.
  logic [11:0] ev_no [4] = '{12'h101, 12'h100, 12'h100, 12'h100};
  logic [11:0] ev_yes [4] = '{12'h100, 12'h101, 12'h101, 12'h0ff};

  task automatic t_event;
    for (int m = 0; m < 4; m++) begin
      cmp_sel <= m[1:0];
      ext_word[3] <= ev_no[m];
      send(K_CTL, 0, 1, CO);
      send(K_DATA, 3, 1, 12'h100);
      send(K_CTL, 0, 1, CI);
      send(K_ADDR, 3, 1, 0);
      send(K_CTL, 0, 1, CX);
      repeat (4) @(posedge clk_i);
      chk(done[3], 0);
      ext_word[3] <= ev_yes[m];
      wsrq();
      chk(done[3], 1);
      send(K_POLL, 0, 0, 0);
    end
    send(K_CTL, 0, 1, CO);
    send(K_DATA, 3, 1, 0);
    chk(armed[3], 0);
  endtask

  task automatic t_group;
    strap <= 1'b1;
    repeat (3) @(posedge clk_i);
    send(K_CTL, 0, 1, CX);
    chk(armed, 4'hf);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    strap <= 1'b0;
    @(posedge clk_i);
    chk(armed, 4'h0);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_digital();
    t_process();
    t_timer();
    t_event();
    t_group();
    conclude();
  end
endmodule // card_interrupt_arming_poll_tb
